// ===== adc_conv_map.svh
// register offsets, field positions, reset values and timing counts of the converter control
// assumes a word-indexed register port; offsets are register indices, not byte addresses
`ifndef ADC_CONV_MAP_SVH
`define ADC_CONV_MAP_SVH

// register indices
`define REG_CTRL            3'h0
`define REG_CHAN            3'h1
`define REG_PINS            3'h2
`define REG_RESULT          3'h3
`define REG_STATUS          3'h4
`define REG_MASK            3'h5

// converter_control_register fields
`define CTRL_POWER_UP       0
`define CTRL_RES10          1
`define CTRL_RIGHT          2
`define CTRL_SIGNED         3
`define CTRL_CONT           4
`define CTRL_WIDTH          5
`define CTRL_RESET          5'h00

// status and mask fields
`define ST_DONE             0
`define ST_ABORT            1
`define ST_BUSY             2
`define EVT_WIDTH           2

`define CHAN_RESET          3'h0
`define PINS_RESET          8'h00

// timing
`define CLK_PERIOD_NS       10
`define CLK_FREQ_HZ         100000000
`define CCLK_FREQ_HZ        2000000
`define CONV_TIME_NS        14000
`define CONV_CYCLES         ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CCLK_HALF_CYCLES    (`CLK_FREQ_HZ / (2 * `CCLK_FREQ_HZ))

`endif

// ===== adc_conv_pkg.sv
// types shared by the converter control logic
// assumes adc_conv_map.svh supplies the numeric constants
package adc_conv_pkg;

    typedef enum logic [2:0]
    {
        ST_OFF  = 3'b001,
        ST_IDLE = 3'b010,
        ST_CONV = 3'b100
    } conv_state_t;

    typedef logic [2:0]  reg_addr_t;
    typedef logic [15:0] reg_data_t;

endpackage

// ===== adc_conversion_control.sv
// control logic of the eight-channel analog_to_digital_unit: registers, sequencing, low power
// assumes a synchronous register master, a front end that presents its code on adc_data_i
// by the end of the conversion window, and a stop_i level from the system clock controller
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "adc_conv_map.svh"

module adc_conversion_control
(
    input  wire logic                  clock_i,
    input  wire logic                  rst_n_i,
    input  wire adc_conv_pkg::reg_addr_t addr_i,
    input  wire adc_conv_pkg::reg_data_t wdata_i,
    input  wire logic                  write_i,
    input  wire logic                  read_i,
    output logic [15:0]                rdata_o,
    input  wire logic                  stop_i,
    input  wire logic [9:0]            adc_data_i,
    output logic                       analog_on_o,
    output logic                       conv_clk_o,
    output logic                       sample_start_o,
    output logic [2:0]                 mux_sel_o,
    output logic [7:0]                 pin_analog_o,
    output logic                       irq_o
);
    import adc_conv_pkg::*;

    function automatic logic hit(input reg_addr_t a, input reg_addr_t idx);
        hit = (a == idx);
    endfunction

    localparam logic [10:0] CONV_LAST = 11'(`CONV_CYCLES - 1);
    localparam logic [4:0]  CCLK_LAST = 5'(`CCLK_HALF_CYCLES - 1);

    logic [`CTRL_WIDTH-1:0] ctrl_q;
    logic [2:0]             chan_q;
    logic [7:0]             pins_q;
    logic [15:0]            result_q;
    logic [`EVT_WIDTH-1:0]  status_q;
    logic [`EVT_WIDTH-1:0]  mask_q;
    conv_state_t            state_q;
    conv_state_t            state_d;
    logic [10:0]            conv_cnt_q;
    logic [4:0]             cclk_cnt_q;
    logic                   done;
    logic                   abort;
    logic                   go;
    logic                   chan_wr;
    logic                   status_wr;
    logic                   power_up;
    logic                   active_ok;
    logic [15:0]            fmt_word;

    assign power_up  = ctrl_q[`CTRL_POWER_UP];
    assign active_ok = power_up && !stop_i;
    assign chan_wr   = write_i && hit(addr_i, `REG_CHAN);
    assign status_wr = write_i && hit(addr_i, `REG_STATUS);
    // a channel register write while powered up and out of stop launches a conversion; a write mid-conversion restarts
    assign go        = chan_wr && active_ok;
    assign done      = (state_q == ST_CONV) && (conv_cnt_q == CONV_LAST) && active_ok;
    // losing power-up or entering stop while converting throws the conversion away
    assign abort     = (state_q == ST_CONV) && !active_ok;

    // result formatting from the raw 10-bit code of the front end
    always_comb
    begin
        fmt_word = 16'h0000;
        if (ctrl_q[`CTRL_RIGHT])
        begin
            if (ctrl_q[`CTRL_RES10])
                fmt_word = {6'h00, adc_data_i};
            else
                fmt_word = {8'h00, adc_data_i[9:2]};
        end
        else if (ctrl_q[`CTRL_RES10])
            fmt_word = {adc_data_i ^ {ctrl_q[`CTRL_SIGNED], 9'h000}, 6'h00};
        else
            fmt_word = {adc_data_i[9:2] ^ {ctrl_q[`CTRL_SIGNED], 7'h00}, 8'h00};
    end

    // control registers: none of them is touched by stop or power-down
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            ctrl_q <= `CTRL_RESET;
            chan_q <= `CHAN_RESET;
            pins_q <= `PINS_RESET;
            mask_q <= '0;
        end
        else if (write_i)
        begin
            // writes are honoured in every state, power-down included
            if (hit(addr_i, `REG_CTRL))
                ctrl_q <= wdata_i[`CTRL_WIDTH-1:0];
            if (chan_wr)
                chan_q <= wdata_i[2:0];
            if (hit(addr_i, `REG_PINS))
                pins_q <= wdata_i[7:0];
            if (hit(addr_i, `REG_MASK))
                mask_q <= wdata_i[`EVT_WIDTH-1:0];
        end
    end

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_OFF:
            begin
                // waking never launches a conversion on its own; only a channel write does,
                // and one landing in the wake-up cycle must not pulse a start that is lost
                if (active_ok && go)
                    state_d = ST_CONV;
                else if (active_ok)
                    state_d = ST_IDLE;
            end
            ST_IDLE:
            begin
                if (!active_ok)
                    state_d = ST_OFF;
                else if (go)
                    state_d = ST_CONV;
            end
            ST_CONV:
            begin
                if (!active_ok)
                    state_d = ST_OFF;
                else if (done && !ctrl_q[`CTRL_CONT] && !go)
                    state_d = ST_IDLE;
            end
            default:
                state_d = ST_OFF;
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            state_q <= ST_OFF;
        else
            state_q <= state_d;
    end

    // conversion window counter
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            conv_cnt_q <= 11'h000;
        else if (go || done || state_q != ST_CONV)
            conv_cnt_q <= 11'h000;
        else
            conv_cnt_q <= conv_cnt_q + 11'h001;
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            result_q <= 16'h0000;
        else if (done)
            result_q <= fmt_word;
    end

    // sticky events; a new event beats a clear written in the same cycle
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            status_q <= '0;
        else
        begin
            status_q[`ST_DONE]  <= done ||
                (status_q[`ST_DONE] && !(status_wr && wdata_i[`ST_DONE]));
            status_q[`ST_ABORT] <= abort ||
                (status_q[`ST_ABORT] && !(status_wr && wdata_i[`ST_ABORT]));
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            irq_o <= 1'b0;
        else
            irq_o <= |(status_q & mask_q);
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            rdata_o <= 16'h0000;
        else if (read_i)
        begin
            case (addr_i)
                `REG_CTRL:   rdata_o <= {11'h000, ctrl_q};
                `REG_CHAN:   rdata_o <= {13'h0000, chan_q};
                `REG_PINS:   rdata_o <= {8'h00, pins_q};
                `REG_RESULT: rdata_o <= result_q;
                `REG_STATUS: rdata_o <= {13'h0000, state_q == ST_CONV, status_q};
                `REG_MASK:   rdata_o <= {14'h0000, mask_q};
                default:     rdata_o <= 16'h0000;
            endcase
        end
        else
            rdata_o <= 16'h0000;
    end

    // front-end controls
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            analog_on_o    <= 1'b0;
            sample_start_o <= 1'b0;
            mux_sel_o      <= `CHAN_RESET;
            pin_analog_o   <= `PINS_RESET;
        end
        else
        begin
            analog_on_o    <= (state_d != ST_OFF);
            sample_start_o <= go || (done && ctrl_q[`CTRL_CONT]);
            mux_sel_o      <= go ? wdata_i[2:0] : chan_q;
            pin_analog_o   <= pins_q;
        end
    end

    // conversion clock divider; held low while powered down so the clock is truly gated
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i || state_d == ST_OFF)
        begin
            cclk_cnt_q <= 5'h00;
            conv_clk_o <= 1'b0;
        end
        else if (cclk_cnt_q == CCLK_LAST)
        begin
            cclk_cnt_q <= 5'h00;
            conv_clk_o <= !conv_clk_o;
        end
        else
            cclk_cnt_q <= cclk_cnt_q + 5'h01;
    end

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence conv_launch;
        state_q == ST_IDLE && go;
    endsequence

    sequence conv_running;
        state_q == ST_CONV && conv_cnt_q < CONV_LAST;
    endsequence

    conv_window_a: assert property (conv_launch |=> conv_running [*8]
        or (state_q == ST_OFF))
        else $error("conversion window ended early");

    done_count_a: assert property (done |-> conv_cnt_q == CONV_LAST && state_q == ST_CONV)
        else $error("conversion finished at wrong count");

    right_fmt_a: assert property (done && ctrl_q[`CTRL_RIGHT] && ctrl_q[`CTRL_RES10]
        |=> result_q[15:10] == 6'h00 && result_q[9:0] == $past(adc_data_i))
        else $error("right justified result wrong");

    signed_fmt_a: assert property (done && !ctrl_q[`CTRL_RIGHT] && ctrl_q[`CTRL_SIGNED]
        && ctrl_q[`CTRL_RES10] |=> result_q[15] == !$past(adc_data_i[9]))
        else $error("signed result sign bit wrong");

    done_irq_a: assert property (done && mask_q[`ST_DONE] |=> ##1 irq_o)
        else $error("completion did not raise interrupt");

    mux_follow_a: assert property (state_q == ST_CONV |-> mux_sel_o == chan_q)
        else $error("mux does not follow channel");

    pin_cfg_a: assert property (write_i && hit(addr_i, `REG_PINS)
        |=> ##1 pin_analog_o == $past(wdata_i[7:0], 2))
        else $error("pin configuration not applied");

    cont_repeat_a: assert property (done && ctrl_q[`CTRL_CONT] && power_up && !stop_i
        |=> state_q == ST_CONV && sample_start_o)
        else $error("continuous mode did not repeat");

    stop_abort_a: assert property (stop_i && state_q == ST_CONV
        |=> state_q == ST_OFF && !analog_on_o && status_q[`ST_ABORT])
        else $error("stop did not abort conversion");

    stop_exit_a: assert property ($fell(stop_i) && !chan_wr |-> state_q != ST_CONV
        ##1 state_q != ST_CONV)
        else $error("conversion started on stop exit");

    stop_wake_a: assert property ($fell(stop_i) && power_up && !write_i
        |=> analog_on_o && state_q == ST_IDLE)
        else $error("block did not wake after stop");

    power_down_a: assert property (!power_up |=> !analog_on_o ##1 !conv_clk_o)
        else $error("power-down left clock or analog on");

    pd_abort_a: assert property (!power_up && state_q == ST_CONV
        |=> state_q == ST_OFF && !done)
        else $error("power-down did not abort");

    power_wake_a: assert property ($rose(power_up) && !stop_i |=> analog_on_o)
        else $error("power-up did not reactivate");

    reset_off_a: assert property ($rose(rst_n_i) |-> state_q == ST_OFF && !power_up)
        else $error("reset did not enter power-down");

    // the enable, the gated clock and the start pulse must agree with the state at all times
    analog_state_a: assert property (analog_on_o == (state_q != ST_OFF))
        else $error("analog enable disagrees with state");

    clk_gated_a: assert property (state_q == ST_OFF |-> !conv_clk_o)
        else $error("conversion clock runs while off");

    start_in_conv_a: assert property (sample_start_o |-> state_q == ST_CONV)
        else $error("sample pulse outside a conversion");

    off_no_start_a: assert property (chan_wr && !active_ok |=> !sample_start_o)
        else $error("channel write started a conversion while off");

    single_end_a: assert property (done && !ctrl_q[`CTRL_CONT] && !go
        |=> state_q == ST_IDLE && !sample_start_o)
        else $error("single conversion did not stop");

    irq_set_a: assert property ((status_q & mask_q) != '0 |=> irq_o)
        else $error("interrupt missing for unmasked event");

    irq_clear_a: assert property ((status_q & mask_q) == '0 |=> !irq_o)
        else $error("interrupt raised with no unmasked event");

endmodule

// ===== adc_front_end_model.sv
// behavioural sample-and-convert front end with its input multiplexer
// assumes the control block holds mux_sel_o steady from the sample pulse on
`timescale 1ns/1ps

module adc_front_end_model
(
    input  wire logic       clock_i,
    input  wire logic       analog_on_i,
    input  wire logic       sample_start_i,
    input  wire logic [2:0] mux_sel_i,
    output logic [9:0]      adc_data_o
);
    initial adc_data_o = 10'h155;

    // the code depends on the channel so a wrong mux setting shows in the result
    always @(posedge clock_i)
    begin
        if (!analog_on_i)
            adc_data_o <= ~adc_data_o;  // unpowered: never a stable code
        else if (sample_start_i)
            adc_data_o <= {mux_sel_i, 7'h4d};
    end
endmodule

// ===== tb_adc_conversion_control.sv
// self-checking bench for the converter control block
// assumes the register map header and the front end model beside it
`timescale 1ns/1ps
`include "adc_conv_map.svh"

module tb_adc_conversion_control;
    import adc_conv_pkg::*;
    logic        clock_i;
    logic        rst_n_i;
    logic        write_i;
    logic        read_i;
    logic        stop_i;
    reg_addr_t   addr_i;
    reg_data_t   wdata_i;
    logic [15:0] rdata_o;
    logic        analog_on_o;
    logic        conv_clk_o;
    logic        sample_start_o;
    logic        irq_o;
    logic [2:0]  mux_sel_o;
    logic [7:0]  pin_analog_o;
    logic [9:0]  adc_data_i;
    int          error_cnt;
    int          total_checks;

    adc_conversion_control dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o),
        .stop_i(stop_i), .adc_data_i(adc_data_i), .analog_on_o(analog_on_o),
        .conv_clk_o(conv_clk_o), .sample_start_o(sample_start_o), .mux_sel_o(mux_sel_o),
        .pin_analog_o(pin_analog_o), .irq_o(irq_o));

    adc_front_end_model front (.clock_i(clock_i), .analog_on_i(analog_on_o),
        .sample_start_i(sample_start_o), .mux_sel_i(mux_sel_o), .adc_data_o(adc_data_i));

    task automatic end_of_test;
        if (error_cnt == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input reg_addr_t a, input reg_data_t d);
        @(posedge clock_i);
        addr_i  <= a;
        wdata_i <= d;
        write_i <= 1'b1;
        @(posedge clock_i);
        write_i <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rdchk(input reg_addr_t a, input reg_data_t exp, input string what);
        @(posedge clock_i);
        addr_i <= a;
        read_i <= 1'b1;
        @(posedge clock_i);
        read_i <= 1'b0;
        #1 check(rdata_o, exp, what);
    endtask

    task automatic pulses(input int cycles, output int p);
        p = 0;
        repeat (cycles)
        begin
            // look at the running cycle first, so a pulse launched by the edge
            // that took the caller's write is not missed
            #1 if (sample_start_o === 1'b1) p++;
            @(posedge clock_i);
        end
    endtask

    task automatic settle;
        repeat (2) @(posedge clock_i);
        #1;
    endtask

    function automatic reg_data_t fmt(input logic [4:0] c, input logic [9:0] d);
        reg_data_t l;
        l = c[1] ? {d, 6'h00} : {d[9:2], 8'h00};
        if (c[2])
            return c[1] ? {6'h00, d} : {8'h00, d[9:2]};
        return c[3] ? {~l[15], l[14:0]} : l;
    endfunction

    task automatic t_reset;
        rdchk(`REG_CTRL, 16'h0000, "ctrl reset");
        check({15'h0, analog_on_o}, 16'h0000, "analog on at reset");
    endtask

    task automatic t_powerdown_regs;
        wr(`REG_PINS, 16'h00a5);
        rdchk(`REG_PINS, 16'h00a5, "pins in power-down");
        check({8'h0, pin_analog_o}, 16'h00a5, "pin roles");
        wr(`REG_CHAN, 16'h0003);
        settle();
        rdchk(`REG_STATUS, 16'h0000, "no start while off");
    endtask

    task automatic t_power_up;
        int n;
        wr(`REG_CTRL, 16'h0001);
        settle();
        check({15'h0, analog_on_o}, 16'h0001, "analog on");
        n = 0;
        while (conv_clk_o !== 1'b1 && n < 100)
        begin
            @(posedge clock_i);
            #1 n++;
        end
        n = 0;
        while (conv_clk_o === 1'b1 && n < 100)
        begin
            @(posedge clock_i);
            #1 n++;
        end
        check(16'(n), 16'd25, "conversion clock half period");
    endtask

    task automatic t_formats;
        logic [4:0] tbl [6] = '{5'h07, 5'h05, 5'h03, 5'h01, 5'h0b, 5'h09};
        int n;
        wr(`REG_MASK, 16'h0001);
        for (int i = 0; i < 6; i++)
        begin
            wr(`REG_CTRL, {11'h0, tbl[i]});
            wr(`REG_CHAN, 16'(i + 2));
            n = 0;
            while (irq_o !== 1'b1 && n < 2000)
            begin
                @(posedge clock_i);
                #1 n++;
            end
            check(16'(n), 16'd1401, "conversion time");
            check({13'h0, mux_sel_o}, 16'(i + 2), "mux channel");
            rdchk(`REG_RESULT, fmt(tbl[i], {3'(i + 2), 7'h4d}), "result format");
            rdchk(`REG_STATUS, 16'h0001, "done flag");
            wr(`REG_STATUS, 16'h0001);
        end
    endtask

    task automatic t_irq_mask;
        wr(`REG_MASK, 16'h0000);
        wr(`REG_CHAN, 16'h0007);
        repeat (1410) @(posedge clock_i);
        #1 check({15'h0, irq_o}, 16'h0000, "masked irq");
        rdchk(`REG_STATUS, 16'h0001, "polled done");
        wr(`REG_MASK, 16'h0001);
        settle();
        check({15'h0, irq_o}, 16'h0001, "irq unmasked");
        wr(`REG_STATUS, 16'h0001);
        settle();
        check({15'h0, irq_o}, 16'h0000, "irq cleared");
    endtask

    task automatic t_continuous;
        int p;
        wr(`REG_CTRL, 16'h0017);
        wr(`REG_CHAN, 16'h0001);
        pulses(2900, p);
        check(16'(p), 16'd3, "back-to-back starts");
        wr(`REG_CTRL, 16'h0001);
        repeat (1500) @(posedge clock_i);
        rdchk(`REG_STATUS, 16'h0001, "continuous ended after current");
        wr(`REG_STATUS, 16'h0003);
    endtask

    task automatic t_stop;
        int p;
        wr(`REG_CHAN, 16'h0002);
        repeat (100) @(posedge clock_i);
        stop_i <= 1'b1;
        settle();
        check({14'h0, analog_on_o, conv_clk_o}, 16'h0000, "analog off in stop");
        rdchk(`REG_CTRL, 16'h0001, "ctrl kept in stop");
        @(posedge clock_i);
        stop_i <= 1'b0;
        settle();
        check({15'h0, analog_on_o}, 16'h0001, "reactivated");
        pulses(1500, p);
        check(16'(p), 16'd0, "no start after stop");
        rdchk(`REG_STATUS, 16'h0002, "stop abort");
        wr(`REG_STATUS, 16'h0003);
    endtask

    task automatic t_pd_abort;
        wr(`REG_CHAN, 16'h0004);
        repeat (100) @(posedge clock_i);
        wr(`REG_CTRL, 16'h0000);
        settle();
        check({14'h0, analog_on_o, conv_clk_o}, 16'h0000, "power-down gating");
        rdchk(`REG_STATUS, 16'h0002, "power-down abort");
        wr(`REG_CTRL, 16'h0001);
        settle();
        check({15'h0, analog_on_o}, 16'h0001, "power back up");
    endtask

    initial
    begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    // all scenarios together take about 16000 cycles
    initial
    begin
        repeat (40000) @(posedge clock_i);
        error_cnt++;
        end_of_test();
    end

    initial
    begin
        rst_n_i = 1'b0;
        write_i = 1'b0;
        read_i  = 1'b0;
        stop_i  = 1'b0;
        addr_i  = 3'h0;
        wdata_i = 16'h0000;
        repeat (12) @(posedge clock_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_powerdown_regs();
        t_power_up();
        t_formats();
        t_irq_mask();
        t_continuous();
        t_stop();
        t_pd_abort();
        end_of_test();
    end
endmodule
